// File: design/cpic_prio.sv
// Rotating priority resolver for one eight-level controller
`timescale 1ns/1ps
module cpic_prio #(
   parameter int N = 8,
   parameter int W = 3
) (
   // Candidates and most urgent level
   input wire logic [N-1:0] req,
   input wire logic [W-1:0] top_lvl,
   // Winner
   output logic found,
   output logic [W-1:0] level
);
   logic [W-1:0] idx;

   // Walk the ring backwards so the level nearest top_lvl is kept; N must be 2**W
   always_comb begin
      idx = top_lvl;
      found = 1'b0;
      level = top_lvl;
      for (int i = N - 1; i >= 0; i--) begin
         idx = top_lvl + W'(i);
         if (req[idx]) begin
            found = 1'b1;
            level = idx;
         end
      end
   end
endmodule : cpic_prio

// File: design/cpic_top.sv
// Cascaded pair of eight-level interrupt controllers, port decode and acknowledge
`timescale 1ns/1ps
`include "cpic_consts.svh"
module cpic_top (
   // Clock and reset
   input wire logic core_clk,
   input wire logic srst,
   // Host I/O cycles and acknowledge
   input wire cpic_pkg::cpic_io_t io_req,
   input wire logic interrupt_acknowledge_cycle,
   output logic [7:0] io_rdata_q,
   output logic io_rdata_valid_q,
   // Toward the CPU
   output logic intr_req,
   output logic [7:0] vector_q,
   output logic vector_valid_q,
   // Peripheral request pins, system interrupts 15..3 and 1..0; pin 2 is not used
   input wire logic [15:0] irq_pin
);
   import cpic_pkg::*;

   logic [15:0] sync1_q;
   logic [15:0] sync2_q;
   logic [7:0] raw [2];
   logic [7:0] prev_q [2];
   logic [7:0] irr_q [2];
   logic [7:0] isr_q [2];
   logic [7:0] mask_q [2];
   logic [2:0] top_q [2];
   logic rot_aeoi_q [2];
   logic smm_q [2];
   logic rd_isr_q [2];
   logic poll_pend_q [2];
   logic [7:0] poll_byte_q [2];
   cpic_init_t st_q [2];
   cpic_cfg_t cfg_q [2];
   logic lvl_permit_q;
   logic [1:0] wr_even;
   logic [1:0] wr_odd;
   logic [1:0] rd_even;
   logic [1:0] rd_odd;
   logic [1:0] is_init1;
   logic [1:0] is_operation_word_two;
   logic [1:0] is_operation_word_three;
   logic [1:0] poll_cmd;
   logic [1:0] take;
   logic [1:0] int_c;
   logic [1:0] rv;
   logic [1:0] iv;
   logic [2:0] rl [2];
   logic [2:0] il [2];
   logic [2:0] take_lvl [2];
   logic ack_ph_q;
   logic frz_casc_q;
   logic [1:0] frz_v_q;
   logic [2:0] frz_lvl_q [2];
   logic ack1;
   logic ack2;
   cpic_cmd_t cmd;
   logic [2:0] cmd_lvl;

   function automatic logic [2:0] urg(input logic [2:0] lvl, input logic [2:0] top);
      return lvl - top;
   endfunction : urg

   assign cmd = cpic_cmd_t'(io_req.wdata[7:5]);
   assign cmd_lvl = io_req.wdata[2:0];
   assign ack1 = interrupt_acknowledge_cycle && !ack_ph_q;
   assign ack2 = interrupt_acknowledge_cycle && ack_ph_q;
   // Request is withdrawn while the acknowledge pair is in progress
   assign intr_req = int_c[0] && !ack_ph_q;

   // Pins are asynchronous to core_clk
   always_ff @(posedge core_clk) begin
      if (srst) begin
         sync1_q <= 16'h0000;
         sync2_q <= 16'h0000;
      end else begin
         sync1_q <= irq_pin;
         sync2_q <= sync1_q;
      end
   end

   assign raw[0] = {sync2_q[7:3], int_c[1], sync2_q[1:0]};
   assign raw[1] = sync2_q[15:8];

   always_ff @(posedge core_clk) begin
      if (srst) begin
         lvl_permit_q <= 1'b0;
      end else if (io_req.wr && io_req.addr == `CPIC_LVL_PERMIT_PORT) begin
         lvl_permit_q <= io_req.wdata[`CPIC_LVL_PERMIT_BIT];
      end
   end

   for (genvar c = 0; c < 2; c++) begin : g_ctl
      localparam logic IS_PRI = (c == 0);
      localparam logic [15:0] EVEN_PORT = IS_PRI ? `CPIC_PRI_EVEN : `CPIC_SEC_EVEN;
      localparam logic [15:0] ODD_PORT = IS_PRI ? `CPIC_PRI_ODD : `CPIC_SEC_ODD;
      localparam logic [7:0] W3_KEEP = IS_PRI ? `CPIC_W3_PRI_KEEP : `CPIC_W3_SEC_KEEP;
      logic [7:0] cand;
      logic nest_ok;
      logic [7:0] isr_clr;
      logic [7:0] isr_set;
      logic [7:0] irr_clr;

      assign wr_even[c] = io_req.wr && io_req.addr == EVEN_PORT;
      assign wr_odd[c] = io_req.wr && io_req.addr == ODD_PORT;
      assign rd_even[c] = io_req.rd && io_req.addr == EVEN_PORT;
      assign rd_odd[c] = io_req.rd && io_req.addr == ODD_PORT;
      assign is_init1[c] = wr_even[c] && io_req.wdata[`CPIC_W1_START];
      assign is_operation_word_two[c] = wr_even[c] && !io_req.wdata[`CPIC_W1_START]
         && !io_req.wdata[`CPIC_OCW_IS3];
      assign is_operation_word_three[c] = wr_even[c] && !io_req.wdata[`CPIC_W1_START]
         && io_req.wdata[`CPIC_OCW_IS3];
      assign poll_cmd[c] = is_operation_word_three[c] && io_req.wdata[`CPIC_OPERATION_WORD_THREE_POLL];

      // Special mask mode only removes levels already in service
      assign cand = irr_q[c] & ~mask_q[c] & (smm_q[c] ? ~isr_q[c] : 8'hFF);

      cpic_prio #(.N(8), .W(3)) u_req (
         .req(cand),
         .top_lvl(top_q[c]),
         .found(rv[c]),
         .level(rl[c])
      );

      cpic_prio #(.N(8), .W(3)) u_isr (
         .req(isr_q[c]),
         .top_lvl(top_q[c]),
         .found(iv[c]),
         .level(il[c])
      );

      // Nested mode lets the cascade level in again so the secondary can nest
      assign nest_ok = IS_PRI && cfg_q[c].sfnm && rl[c] == `CPIC_CASC_LEVEL
         && il[c] == `CPIC_CASC_LEVEL;
      assign int_c[c] = rv[c] && (smm_q[c] || !iv[c]
         || urg(rl[c], top_q[c]) < urg(il[c], top_q[c]) || nest_ok);

      if (IS_PRI) begin : g_take_pri
         assign take[c] = poll_cmd[c] ? int_c[c] : ack2 && frz_v_q[c];
      end else begin : g_take_sec
         assign take[c] = poll_cmd[c] ? int_c[c] : ack2 && frz_casc_q && frz_v_q[c];
      end
      assign take_lvl[c] = poll_cmd[c] ? rl[c] : frz_lvl_q[c];

      // Initialization word sequence
      always_ff @(posedge core_clk) begin
         if (srst) begin
            st_q[c] <= CPIC_READY;
            cfg_q[c] <= '0;
         end else if (is_init1[c]) begin
            st_q[c] <= CPIC_W2;
            cfg_q[c].single <= io_req.wdata[`CPIC_W1_SINGLE];
            cfg_q[c].need4 <= io_req.wdata[`CPIC_W1_NEED4];
            cfg_q[c].level_mode <= io_req.wdata[`CPIC_W1_LEVEL] && lvl_permit_q;
            cfg_q[c].sfnm <= 1'b0;
            cfg_q[c].aeoi <= 1'b0;
         end else if (wr_odd[c]) begin
            case (st_q[c])
               CPIC_W2: begin
                  cfg_q[c].vec_word <= io_req.wdata;
                  if (!cfg_q[c].single) begin
                     st_q[c] <= CPIC_W3;
                  end else if (cfg_q[c].need4 && IS_PRI) begin
                     st_q[c] <= CPIC_W4;
                  end else begin
                     st_q[c] <= CPIC_READY;
                  end
               end
               CPIC_W3: begin
                  cfg_q[c].casc_word <= io_req.wdata & W3_KEEP;
                  st_q[c] <= (cfg_q[c].need4 && IS_PRI) ? CPIC_W4 : CPIC_READY;
               end
               CPIC_W4: begin
                  cfg_q[c].sfnm <= io_req.wdata[`CPIC_W4_SFNM];
                  cfg_q[c].aeoi <= io_req.wdata[`CPIC_W4_AEOI];
                  st_q[c] <= CPIC_READY;
               end
               default: begin
               end
            endcase
         end
      end

      always_ff @(posedge core_clk) begin
         if (srst || is_init1[c]) begin
            mask_q[c] <= `CPIC_MASK_RESET;
         end else if (wr_odd[c] && st_q[c] == CPIC_READY) begin
            mask_q[c] <= io_req.wdata;
         end
      end

      always_ff @(posedge core_clk) begin
         if (srst || is_init1[c]) begin
            smm_q[c] <= 1'b0;
            rd_isr_q[c] <= 1'b0;
         end else if (is_operation_word_three[c]) begin
            if (io_req.wdata[`CPIC_OPERATION_WORD_THREE_SMM_EN]) begin
               smm_q[c] <= io_req.wdata[`CPIC_OPERATION_WORD_THREE_SMM];
            end
            if (io_req.wdata[`CPIC_OPERATION_WORD_THREE_RR_EN]) begin
               rd_isr_q[c] <= io_req.wdata[`CPIC_OPERATION_WORD_THREE_RR_SEL];
            end
         end
      end

      // Priority order; a command in the same cycle as a take wins
      always_ff @(posedge core_clk) begin
         if (srst || is_init1[c]) begin
            top_q[c] <= `CPIC_TOP_RESET;
            rot_aeoi_q[c] <= 1'b0;
         end else if (is_operation_word_two[c]) begin
            case (cmd)
               CPIC_ROT_AEOI_CLR: rot_aeoi_q[c] <= 1'b0;
               CPIC_ROT_AEOI_SET: rot_aeoi_q[c] <= 1'b1;
               CPIC_ROT_NS_EOI: begin
                  if (iv[c]) begin
                     top_q[c] <= il[c] + 3'h1;
                  end
               end
               CPIC_SET_PRIO, CPIC_ROT_SP_EOI: top_q[c] <= cmd_lvl + 3'h1;
               default: begin
               end
            endcase
         end else if (take[c] && cfg_q[c].aeoi && rot_aeoi_q[c]) begin
            top_q[c] <= take_lvl[c] + 3'h1;
         end
      end

      always_comb begin
         isr_clr = 8'h00;
         isr_set = 8'h00;
         irr_clr = 8'h00;
         if (is_operation_word_two[c] && (cmd == CPIC_NS_EOI || cmd == CPIC_ROT_NS_EOI) && iv[c]) begin
            isr_clr[il[c]] = 1'b1;
         end
         if (is_operation_word_two[c] && (cmd == CPIC_SP_EOI || cmd == CPIC_ROT_SP_EOI)) begin
            isr_clr[cmd_lvl] = 1'b1;
         end
         if (take[c]) begin
            irr_clr[take_lvl[c]] = 1'b1;
            // Automatic end leaves the level out of service at once
            isr_set[take_lvl[c]] = !cfg_q[c].aeoi;
         end
      end

      // A take in the same cycle as an end command keeps its bit
      always_ff @(posedge core_clk) begin
         if (srst || is_init1[c]) begin
            isr_q[c] <= 8'h00;
         end else begin
            isr_q[c] <= (isr_q[c] & ~isr_clr) | isr_set;
         end
      end

      always_ff @(posedge core_clk) begin
         if (srst) begin
            prev_q[c] <= 8'h00;
         end else begin
            prev_q[c] <= raw[c];
         end
      end

      // New rising edge beats the acknowledge clear
      always_ff @(posedge core_clk) begin
         if (srst || is_init1[c]) begin
            irr_q[c] <= 8'h00;
         end else if (cfg_q[c].level_mode) begin
            irr_q[c] <= raw[c];
         end else begin
            irr_q[c] <= (irr_q[c] & ~irr_clr) | (raw[c] & ~prev_q[c]);
         end
      end

      always_ff @(posedge core_clk) begin
         if (srst || is_init1[c]) begin
            poll_pend_q[c] <= 1'b0;
            poll_byte_q[c] <= `CPIC_BYTE_RESET;
         end else if (poll_cmd[c]) begin
            poll_pend_q[c] <= 1'b1;
            poll_byte_q[c] <= {int_c[c], 4'h0, rl[c]};
         end else if (rd_even[c] || rd_odd[c]) begin
            poll_pend_q[c] <= 1'b0;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         ack_ph_q <= 1'b0;
      end else if (interrupt_acknowledge_cycle) begin
         ack_ph_q <= !ack_ph_q;
      end
   end

   // Decision is taken once so late arrivals cannot change the vector
   always_ff @(posedge core_clk) begin
      if (srst) begin
         frz_v_q <= 2'h0;
         frz_casc_q <= 1'b0;
         frz_lvl_q[0] <= `CPIC_SPURIOUS_LEVEL;
         frz_lvl_q[1] <= `CPIC_SPURIOUS_LEVEL;
      end else if (ack1) begin
         frz_v_q <= int_c;
         frz_lvl_q[0] <= int_c[0] ? rl[0] : `CPIC_SPURIOUS_LEVEL;
         frz_lvl_q[1] <= int_c[1] ? rl[1] : `CPIC_SPURIOUS_LEVEL;
         frz_casc_q <= int_c[0] && rl[0] == `CPIC_CASC_LEVEL && !cfg_q[0].single
            && cfg_q[0].casc_word[`CPIC_W3_HAS_SEC];
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         vector_q <= `CPIC_BYTE_RESET;
         vector_valid_q <= 1'b0;
      end else begin
         vector_valid_q <= ack2;
         if (ack2) begin
            vector_q <= frz_casc_q ? {cfg_q[1].vec_word[7:3], frz_lvl_q[1]}
               : {cfg_q[0].vec_word[7:3], frz_lvl_q[0]};
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         io_rdata_q <= `CPIC_BYTE_RESET;
         io_rdata_valid_q <= 1'b0;
      end else begin
         io_rdata_valid_q <= io_req.rd;
         if (io_req.rd) begin
            io_rdata_q <= `CPIC_BYTE_RESET;
            for (int k = 0; k < 2; k++) begin
               if (poll_pend_q[k] && (rd_even[k] || rd_odd[k])) begin
                  io_rdata_q <= poll_byte_q[k];
               end else if (rd_even[k]) begin
                  io_rdata_q <= rd_isr_q[k] ? isr_q[k] : irr_q[k];
               end else if (rd_odd[k]) begin
                  io_rdata_q <= mask_q[k];
               end
            end
            if (io_req.addr == `CPIC_PRI_VEC_READ) begin
               io_rdata_q <= cfg_q[0].vec_word;
            end
            if (io_req.addr == `CPIC_SEC_VEC_READ) begin
               io_rdata_q <= cfg_q[1].vec_word;
            end
         end
      end
   end

   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (srst);

   fixed_order_a: assert property (rv[0] && top_q[0] == 3'h0
      |-> (g_ctl[0].cand & ((8'h01 << rl[0]) - 8'h01)) == 8'h00)
      else $error("a more urgent fixed level was skipped");
   auto_rotate_a: assert property (is_operation_word_two[0] && cmd == CPIC_ROT_NS_EOI && iv[0]
      |=> top_q[0] == $past(il[0]) + 3'h1)
      else $error("serviced level did not become least urgent");
   spec_rotate_a: assert property (is_operation_word_two[0] && cmd == CPIC_SET_PRIO
      |=> top_q[0] == $past(cmd_lvl) + 3'h1)
      else $error("named level did not become least urgent");
   req_unmasked_a: assert property (intr_req |-> (irr_q[0] & ~mask_q[0]) != 8'h00)
      else $error("request raised with no unmasked pending level");
   freeze_level_a: assert property (ack1 ##1 !interrupt_acknowledge_cycle |=> frz_lvl_q[0] == $past(frz_lvl_q[0]))
      else $error("frozen level moved between acknowledges");
   vector_out_a: assert property (ack2 && !frz_casc_q
      |=> vector_valid_q && vector_q[2:0] == $past(frz_lvl_q[0]))
      else $error("vector not driven with frozen level");
   isr_on_ack_a: assert property (ack2 && frz_v_q[0] && !cfg_q[0].aeoi && !is_operation_word_two[0]
      |=> isr_q[0][$past(frz_lvl_q[0])])
      else $error("in-service bit not set by second acknowledge");
   nest_block_a: assert property (iv[0] && !smm_q[0] && !cfg_q[0].sfnm && int_c[0]
      |-> urg(rl[0], top_q[0]) < urg(il[0], top_q[0]))
      else $error("request at or below in-service level passed");
   spec_eoi_a: assert property (is_operation_word_two[0] && cmd == CPIC_SP_EOI && !take[0]
      |=> !isr_q[0][$past(cmd_lvl)])
      else $error("specific end did not clear named level");
   init_start_a: assert property (is_init1[0] |=> st_q[0] == CPIC_W2)
      else $error("first word did not start the sequence");
   ocw_decode_a: assert property (is_operation_word_two[0] |=> st_q[0] == $past(st_q[0]))
      else $error("operation word disturbed the init sequence");
   sec_no_four_a: assert property (st_q[1] != CPIC_W4)
      else $error("secondary waited for a fourth word");

   cover property (ack2 && frz_casc_q && frz_v_q[1]);
   cover property (poll_cmd[0] && int_c[0]);
   cover property (st_q[0] == CPIC_W4 ##1 st_q[0] == CPIC_READY);
   cover property (take[0] && cfg_q[0].aeoi && rot_aeoi_q[0]);
endmodule : cpic_top

// File: include/cpic_consts.svh
// Port map, field positions and reset values of the interrupt controller pair
`ifndef CPIC_CONSTS_SVH
`define CPIC_CONSTS_SVH
`define CPIC_PRI_EVEN 16'h0020
`define CPIC_PRI_ODD 16'h0021
`define CPIC_SEC_EVEN 16'h00A0
`define CPIC_SEC_ODD 16'h00A1
`define CPIC_LVL_PERMIT_PORT 16'hA872
`define CPIC_PRI_VEC_READ 16'hD472
`define CPIC_SEC_VEC_READ 16'hD473
`define CPIC_LVL_PERMIT_BIT 0
`define CPIC_W1_START 4
`define CPIC_W1_LEVEL 3
`define CPIC_W1_SINGLE 1
`define CPIC_W1_NEED4 0
`define CPIC_W3_HAS_SEC 2
`define CPIC_W3_PRI_KEEP 8'h04
`define CPIC_W3_SEC_KEEP 8'h07
`define CPIC_W4_SFNM 4
`define CPIC_W4_AEOI 1
`define CPIC_OCW_IS3 3
`define CPIC_OPERATION_WORD_THREE_SMM_EN 6
`define CPIC_OPERATION_WORD_THREE_SMM 5
`define CPIC_OPERATION_WORD_THREE_POLL 2
`define CPIC_OPERATION_WORD_THREE_RR_EN 1
`define CPIC_OPERATION_WORD_THREE_RR_SEL 0
`define CPIC_CASC_LEVEL 3'h2
`define CPIC_SPURIOUS_LEVEL 3'h7
`define CPIC_TOP_RESET 3'h0
`define CPIC_MASK_RESET 8'h00
`define CPIC_BYTE_RESET 8'h00
`endif

// File: include/cpic_pkg.sv
// Types shared by the interrupt controller pair
package cpic_pkg;
   typedef enum logic [1:0] {
      CPIC_READY = 2'h0,
      CPIC_W2 = 2'h1,
      CPIC_W3 = 2'h3,
      CPIC_W4 = 2'h2
   } cpic_init_t;
   typedef enum logic [2:0] {
      CPIC_ROT_AEOI_CLR = 3'h0,
      CPIC_NS_EOI = 3'h1,
      CPIC_CMD_UNUSED = 3'h2,
      CPIC_SP_EOI = 3'h3,
      CPIC_ROT_AEOI_SET = 3'h4,
      CPIC_ROT_NS_EOI = 3'h5,
      CPIC_SET_PRIO = 3'h6,
      CPIC_ROT_SP_EOI = 3'h7
   } cpic_cmd_t;
   typedef struct packed {
      logic [15:0] addr;
      logic wr;
      logic rd;
      logic [7:0] wdata;
   } cpic_io_t;
   typedef struct packed {
      logic [7:0] vec_word;
      logic [7:0] casc_word;
      logic single;
      logic need4;
      logic level_mode;
      logic sfnm;
      logic aeoi;
   } cpic_cfg_t;
endpackage : cpic_pkg

// File: verif/cpic_host_model.sv
// Host processor and peripheral request pins facing the controller pair
`timescale 1ns/1ps
module cpic_host_model (
   // Clock
   input wire logic core_clk,
   // I/O cycles and acknowledge
   output cpic_pkg::cpic_io_t io_req,
   output logic interrupt_acknowledge_cycle,
   input wire logic [7:0] io_rdata_q,
   input wire logic io_rdata_valid_q,
   // Answers toward the processor
   input wire logic intr_req,
   input wire logic [7:0] vector_q,
   input wire logic vector_valid_q,
   // Peripheral request pins
   output logic [15:0] irq_pin
);
   import cpic_pkg::*;
   initial begin
      io_req = '0;
      interrupt_acknowledge_cycle = 1'b0;
      irq_pin = 16'h0000;
   end
   // One-cycle strobe; released bus is scrambled so stale values never match
   task automatic cycle(input logic [15:0] a, input logic w, input logic [7:0] d);
      @(posedge core_clk);
      io_req <= {a, w, ~w, d};
      @(posedge core_clk);
      io_req <= {~a, 1'b0, 1'b0, ~d};
   endtask : cycle
   // Init words, mask and command bytes, end commands to both controllers
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      cycle(a, 1'b1, d);
   endtask : wr
   // Missing valid shows as unknown so it can never compare equal
   task automatic rd(input logic [15:0] a, output logic [7:0] d);
      cycle(a, 1'b0, 8'h00);
      // Answer stands only in the cycle after the strobe edge
      #1 d = io_rdata_valid_q ? io_rdata_q : 8'hXX;
   endtask : rd
   // Two acknowledge pulses with a gap; request sampled between them
   task automatic ack(output logic mid, output logic [7:0] v);
      @(posedge core_clk);
      interrupt_acknowledge_cycle <= 1'b1;
      @(posedge core_clk);
      interrupt_acknowledge_cycle <= 1'b0;
      @(posedge core_clk);
      #1 mid = intr_req;
      @(posedge core_clk);
      interrupt_acknowledge_cycle <= 1'b1;
      @(posedge core_clk);
      interrupt_acknowledge_cycle <= 1'b0;
      // Vector stands only in the cycle after the second pulse edge
      #1 v = vector_valid_q ? vector_q : 8'hXX;
   endtask : ack
   // Rise, hold past the synchronizer, fall so the next rise counts again
   task automatic pulse(input logic [15:0] m);
      @(posedge core_clk);
      irq_pin <= m;
      repeat (4) @(posedge core_clk);
      irq_pin <= 16'h0000;
   endtask : pulse
endmodule : cpic_host_model

// File: verif/tb_cpic_top.sv
// Self-checking bench for the cascaded interrupt controller pair
`timescale 1ns/1ps
module tb_cpic_top;
   import cpic_pkg::*;
   logic core_clk = 1'b0;
   logic srst = 1'b1;
   cpic_io_t io_req;
   logic interrupt_acknowledge_cycle, intr_req, io_rdata_valid_q, vector_valid_q, mid;
   logic [7:0] io_rdata_q, vector_q, got;
   logic [15:0] irq_pin;
   int error_cnt = 0;
   int total_checks = 0;
   always #2.5 core_clk = ~core_clk;
   cpic_top DUT (.core_clk(core_clk), .srst(srst), .io_req(io_req), .interrupt_acknowledge_cycle(interrupt_acknowledge_cycle),
      .io_rdata_q(io_rdata_q), .io_rdata_valid_q(io_rdata_valid_q), .intr_req(intr_req),
      .vector_q(vector_q), .vector_valid_q(vector_valid_q), .irq_pin(irq_pin));
   cpic_host_model host (.core_clk(core_clk), .io_req(io_req), .interrupt_acknowledge_cycle(interrupt_acknowledge_cycle),
      .io_rdata_q(io_rdata_q), .io_rdata_valid_q(io_rdata_valid_q), .intr_req(intr_req),
      .vector_q(vector_q), .vector_valid_q(vector_valid_q), .irq_pin(irq_pin));
   task automatic chk_byte(input logic [7:0] g, input logic [7:0] e);
      total_checks++;
      if (g !== e) begin
         error_cnt++;
         $display("Error at %0t: got %h expected %h", $time, g, e);
      end
   endtask : chk_byte
   task automatic chk_bit(input logic g, input logic e);
      total_checks++;
      if (g !== e) begin
         error_cnt++;
         $display("Error at %0t: request got %h expected %h", $time, g, e);
      end
   endtask : chk_bit
   task automatic rdc(input logic [15:0] a, input logic [7:0] e);
      host.rd(a, got);
      chk_byte(got, e);
   endtask : rdc
   // Request must be gone between the pulses
   task automatic akc(input logic [7:0] e);
      host.ack(mid, got);
      chk_bit(mid, 1'b0);
      chk_byte(got, e);
   endtask : akc
   task automatic req(input logic e);
      @(posedge core_clk);
      #1 chk_bit(intr_req, e);
   endtask : req
   task automatic final_report();
      $display("Checks %0d, errors %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : final_report
   // Whole sequence needs well under a thousand cycles
   initial begin
      #20000;
      error_cnt++;
      final_report();
   end
   initial begin
      repeat (4) @(posedge core_clk);
      srst <= 1'b0;
      rdc(16'h0021, 8'h00);
      host.wr(16'h0020, 8'h11);
      host.wr(16'h0021, 8'h08);
      host.wr(16'h0021, 8'h04);
      host.wr(16'h0021, 8'h01);
      host.wr(16'h00A0, 8'h11);
      host.wr(16'h00A1, 8'h70);
      host.wr(16'h00A1, 8'h02);
      rdc(16'hD472, 8'h08);
      rdc(16'hD473, 8'h70);
      // Two requests at once, fixed order
      host.pulse(16'h0028);
      req(1'b1);
      akc(8'h0B);
      req(1'b0);
      host.wr(16'h0020, 8'h0B);
      rdc(16'h0020, 8'h08);
      host.wr(16'h0020, 8'h20);
      rdc(16'h0020, 8'h00);
      req(1'b1);
      akc(8'h0D);
      host.wr(16'h0020, 8'h0A);
      rdc(16'h0020, 8'h00);
      host.wr(16'h0020, 8'h20);
      // Masked level stays quiet until unmasked
      host.wr(16'h0021, 8'h40);
      host.pulse(16'h0040);
      req(1'b0);
      rdc(16'h0021, 8'h40);
      host.wr(16'h0021, 8'h00);
      req(1'b1);
      akc(8'h0E);
      host.wr(16'h0020, 8'h0B);
      host.wr(16'h0020, 8'h66);
      rdc(16'h0020, 8'h00);
      // Level 4 named least urgent
      host.wr(16'h0020, 8'hC4);
      host.pulse(16'h0048);
      akc(8'h0E);
      host.wr(16'h0020, 8'h20);
      akc(8'h0B);
      host.wr(16'h0020, 8'h20);
      // Rotation on end command
      host.wr(16'h0020, 8'hC7);
      host.pulse(16'h0002);
      akc(8'h09);
      host.wr(16'h0020, 8'hA0);
      host.pulse(16'h0009);
      akc(8'h0B);
      host.wr(16'h0020, 8'hA0);
      akc(8'h08);
      host.wr(16'h0020, 8'hA0);
      host.wr(16'h0020, 8'hC7);
      // Secondary level 5 through primary level 2
      host.pulse(16'h2000);
      akc(8'h75);
      host.wr(16'h0020, 8'h0B);
      rdc(16'h0020, 8'h04);
      host.wr(16'h00A0, 8'h0B);
      rdc(16'h00A0, 8'h20);
      host.pulse(16'h0100);
      req(1'b0);
      host.wr(16'h00A0, 8'h20);
      rdc(16'h00A0, 8'h00);
      req(1'b0);
      host.wr(16'h0020, 8'h20);
      req(1'b1);
      akc(8'h70);
      host.wr(16'h00A0, 8'h20);
      host.wr(16'h0020, 8'h20);
      // Poll in place of an acknowledge
      host.pulse(16'h0010);
      host.wr(16'h0020, 8'h0C);
      rdc(16'h0020, 8'h84);
      host.wr(16'h0020, 8'h0B);
      rdc(16'h0020, 8'h10);
      host.wr(16'h0020, 8'h20);
      // Re-init with nested mode and automatic end
      host.wr(16'h0020, 8'h11);
      host.wr(16'h0021, 8'h08);
      host.wr(16'h0021, 8'h04);
      host.wr(16'h0021, 8'h13);
      host.pulse(16'h0020);
      akc(8'h0D);
      host.wr(16'h0020, 8'h0B);
      rdc(16'h0020, 8'h00);
      // Masked pins still latch; remaining system inputs reach both controllers
      host.wr(16'h0021, 8'h80);
      host.wr(16'h00A1, 8'hFF);
      host.pulse(16'hDE80);
      req(1'b0);
      host.wr(16'h0020, 8'h0A);
      rdc(16'h0020, 8'h80);
      host.wr(16'h00A0, 8'h0A);
      rdc(16'h00A0, 8'hDE);
      // Level mode with permit: pending follows the pin and drops with it
      host.wr(16'hA872, 8'h01);
      host.wr(16'h00A0, 8'h19);
      host.wr(16'h00A1, 8'h70);
      host.wr(16'h00A1, 8'h02);
      host.wr(16'h00A1, 8'hFF);
      host.pulse(16'h1200);
      req(1'b0);
      req(1'b0);
      rdc(16'h00A0, 8'h00);
      final_report();
   end
endmodule : tb_cpic_top
